// file: src/frtc_map.vh
// Purpose: Constants for the free-running timer with edge capture
// Assumes: 125 MHz system clock, 1 MHz timebase derived internally
// Notes: Register offsets are kept for reference; there is no bus here
`ifndef FRTC_MAP_VH
`define FRTC_MAP_VH

`define FRTC_CLK_MHZ        125
`define FRTC_TB_MHZ         1
`define FRTC_TB_DIV         (`FRTC_CLK_MHZ / `FRTC_TB_MHZ)
`define FRTC_TB_DIV_W       7
`define FRTC_TB_LAST        7'h7c
`define FRTC_CNT_W          12
`define FRTC_TICK128_BIT    4'h7
`define FRTC_TICK1024_BIT   4'ha
`define FRTC_PRESC_W        3
`define FRTC_PRESC_MAX      3'h4
`define FRTC_CNT_RST        12'h000
`define FRTC_CAP_RST        8'h00

`define FRTC_OFS_TMR_LO     8'h24
`define FRTC_OFS_TMR_HI     8'h25
`define FRTC_OFS_CAP_AR     8'h40
`define FRTC_OFS_CAP_AF     8'h41
`define FRTC_OFS_CAP_BR     8'h42
`define FRTC_OFS_CAP_BF     8'h43
`define FRTC_OFS_CAP_CFG    8'h44
`define FRTC_OFS_CAP_STAT   8'h45

`endif

// file: src/frtc_edge_sync.v
// Purpose: Two-flop synchroniser with edge detection for one capture input
// Assumes: Input may be asynchronous to clk_sys
// Notes: Edge pulses come one cycle after the second flop settles
`timescale 1ns/1ns
`default_nettype none
module frtc_edge_sync (
    input  wire clk_sys,
    input  wire rst,
    input  wire pin_in,
    output reg  rise_o,
    output reg  fall_o
);
    reg meta_r;
    reg sync_r;
    reg prev_r;

    // ==========================================
    // Synchroniser and edge detector
    always @(posedge clk_sys) begin
        if (rst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
            rise_o <= 1'b0;
            fall_o <= 1'b0;
        end else begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
            rise_o <= sync_r & ~prev_r;
            fall_o <= ~sync_r & prev_r;
        end
    end
endmodule
`default_nettype wire

// file: src/frtc_top.v
// Purpose: 12-bit free-running timer with two edge-capture channels
// Assumes: Port 0 pins arrive as a bus; software access is outside this block
// Notes: Capture values and status are plain outputs, no register bus
`timescale 1ns/1ns
`default_nettype none
`include "frtc_map.vh"
module frtc_top (
    input  wire                      clk_sys,
    input  wire                      rst,
    input  wire [7:0]                port0_in,
    input  wire                      tick128_en,
    input  wire                      tick1024_en,
    input  wire                      cap_a_int_en,
    input  wire                      cap_b_int_en,
    input  wire [`FRTC_PRESC_W-1:0]  cap_presc,
    input  wire                      cap_first_only,
    input  wire [3:0]                cap_stat_clr,
    output reg  [7:0]                timer_lo,
    output reg  [3:0]                timer_hi,
    output reg  [7:0]                cap_a_rise,
    output reg  [7:0]                cap_a_fall,
    output reg  [7:0]                cap_b_rise,
    output reg  [7:0]                cap_b_fall,
    output reg  [3:0]                cap_stat,
    output reg                       irq_tick128,
    output reg                       irq_tick1024,
    output reg                       irq_cap_a,
    output reg                       irq_cap_b
);
    // ==========================================
    // Slice selection
    // Settings above the last legal one clamp to it rather than capture junk
    function [7:0] slice_sel;
        input [`FRTC_CNT_W-1:0]   cnt;
        input [`FRTC_PRESC_W-1:0] ps;
        begin
            case (ps)
                3'h0:    slice_sel = cnt[7:0];
                3'h1:    slice_sel = cnt[8:1];
                3'h2:    slice_sel = cnt[9:2];
                3'h3:    slice_sel = cnt[10:3];
                default: slice_sel = cnt[11:4];
            endcase
        end
    endfunction

    reg [`FRTC_TB_DIV_W-1:0] div_r;
    reg [`FRTC_CNT_W-1:0]    cnt_r;
    reg                      tb_r;
    wire                     capture_a_input;
    wire                     capture_b_input;
    wire                     a_rise;
    wire                     a_fall;
    wire                     b_rise;
    wire                     b_fall;
    wire [7:0]               slice;
    wire [3:0]               ev;
    wire [3:0]               load;
    wire [`FRTC_CNT_W-1:0]   cnt_nxt;

    assign capture_a_input = port0_in[0];
    assign capture_b_input = port0_in[1];
    assign slice           = slice_sel(cnt_r, cap_presc);
    assign ev              = {b_fall, b_rise, a_fall, a_rise};
    // First-only mode holds a value until its status bit is cleared
    assign load            = ev & ~(cap_first_only ? cap_stat : 4'h0);
    assign cnt_nxt         = cnt_r + 12'h001;

    frtc_edge_sync u_sync_a (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  (capture_a_input),
        .rise_o  (a_rise),
        .fall_o  (a_fall)
    );

    frtc_edge_sync u_sync_b (
        .clk_sys (clk_sys),
        .rst     (rst),
        .pin_in  (capture_b_input),
        .rise_o  (b_rise),
        .fall_o  (b_fall)
    );

    // ==========================================
    // Timebase and free-running counter
    // Dividing the system clock keeps every counter step exactly 1 us long
    always @(posedge clk_sys) begin
        if (rst) begin
            div_r <= {`FRTC_TB_DIV_W{1'b0}};
        end else if (div_r == `FRTC_TB_LAST) begin
            div_r <= {`FRTC_TB_DIV_W{1'b0}};
        end else begin
            div_r <= div_r + 7'h01;
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            tb_r <= 1'b0;
        end else begin
            tb_r <= (div_r == `FRTC_TB_LAST);
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            cnt_r <= `FRTC_CNT_RST;
        end else if (tb_r) begin
            cnt_r <= cnt_nxt;
        end
    end

    // ==========================================
    // Periodic ticks
    // One helper decodes both tick periods from the low bits of the next count
    function low_zero;
        input [`FRTC_CNT_W-1:0] cnt;
        input [3:0]             nbits;
        integer                 i;
        begin
            low_zero = 1'b1;
            for (i = 0; i < `FRTC_CNT_W; i = i + 1) begin
                if ((i < nbits) && cnt[i]) begin
                    low_zero = 1'b0;
                end
            end
        end
    endfunction

    wire                     tick128_hit;
    wire                     tick1024_hit;

    assign tick128_hit  = tb_r & low_zero(cnt_nxt, `FRTC_TICK128_BIT);
    assign tick1024_hit = tb_r & low_zero(cnt_nxt, `FRTC_TICK1024_BIT);

    always @(posedge clk_sys) begin
        if (rst) begin
            irq_tick128  <= 1'b0;
            irq_tick1024 <= 1'b0;
        end else begin
            irq_tick128  <= tick128_en & tick128_hit;
            irq_tick1024 <= tick1024_en & tick1024_hit;
        end
    end

    // ==========================================
    // Counter view
    // Both halves come from one counter value, so a read pair is coherent
    always @(posedge clk_sys) begin
        if (rst) begin
            timer_lo <= 8'h00;
            timer_hi <= 4'h0;
        end else begin
            timer_lo <= cnt_r[7:0];
            timer_hi <= cnt_r[11:8];
        end
    end

    // ==========================================
    // Capture registers
    // Each edge has its own register so a rise never overwrites a fall
    always @(posedge clk_sys) begin
        if (rst) begin
            cap_a_rise <= `FRTC_CAP_RST;
            cap_a_fall <= `FRTC_CAP_RST;
        end else begin
            if (load[0]) begin
                cap_a_rise <= slice;
            end
            if (load[1]) begin
                cap_a_fall <= slice;
            end
        end
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            cap_b_rise <= `FRTC_CAP_RST;
            cap_b_fall <= `FRTC_CAP_RST;
        end else begin
            if (load[2]) begin
                cap_b_rise <= slice;
            end
            if (load[3]) begin
                cap_b_fall <= slice;
            end
        end
    end

    // ==========================================
    // Capture status and interrupts
    // Set wins over clear so an edge in the clear cycle survives unless first-only mode masks it
    reg [3:0]                cap_stat_nxt;

    always @* begin
        cap_stat_nxt = (cap_stat & ~cap_stat_clr) | load;
    end

    always @(posedge clk_sys) begin
        if (rst) begin
            cap_stat <= 4'h0;
        end else begin
            cap_stat <= cap_stat_nxt;
        end
    end

    // A channel interrupt is one pulse per load, whichever edge caused it
    function chan_irq;
        input       en;
        input [1:0] ld;
        begin
            chan_irq = en & (ld[0] | ld[1]);
        end
    endfunction

    always @(posedge clk_sys) begin
        if (rst) begin
            irq_cap_a <= 1'b0;
            irq_cap_b <= 1'b0;
        end else begin
            irq_cap_a <= chan_irq(cap_a_int_en, load[1:0]);
            irq_cap_b <= chan_irq(cap_b_int_en, load[3:2]);
        end
    end
endmodule
`default_nettype wire

// file: sim/frtc_top_asserts.sv
// Purpose: Port checks for frtc_top
// Assumes: Capture is visible at the fourth edge after the pin sample
// Notes: Tick spacing is counted in helper logic
`timescale 1ns/1ns
`default_nettype none
module frtc_chk (
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [7:0] port0_in,
    input wire logic       tick128_en,
    input wire logic       tick1024_en,
    input wire logic       cap_a_int_en,
    input wire logic       cap_b_int_en,
    input wire logic [7:0] timer_lo,
    input wire logic [3:0] timer_hi,
    input wire logic [3:0] cap_stat,
    input wire logic       irq_tick128,
    input wire logic       irq_tick1024,
    input wire logic       irq_cap_a,
    input wire logic       irq_cap_b
);
    // ==========================================
    // Tick spacing helper
    logic [15:0] gap_r;
    logic        seen_r;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gap_r <= 16'h0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= irq_tick128 ? 16'h1 : gap_r + 16'h1;
            seen_r <= seen_r | irq_tick128;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_tick_gap: assert property (irq_tick128 && seen_r |-> gap_r == 16'h3e80) else $error("tick spacing");
    a_tick_en: assert property (irq_tick128 |-> $past(tick128_en)) else $error("tick while off");
    a_slow_tick: assert property (irq_tick1024 |-> $past(tick1024_en)) else $error("slow tick off");
    a_timer_step: assert property ($changed({timer_hi, timer_lo}) |->
        {timer_hi, timer_lo} == $past({timer_hi, timer_lo}) + 12'h1) else $error("timer step");
    a_timer_hold: assert property ($changed(timer_lo) |=> $stable(timer_lo) [*8]) else $error("timer fast");
    a_rise_a: assert property ($rose(port0_in[0]) |-> ##4 cap_stat[0]) else $error("a rise");
    a_fall_a: assert property ($fell(port0_in[0]) |-> ##4 cap_stat[1]) else $error("a fall");
    a_rise_b: assert property ($rose(port0_in[1]) |-> ##4 cap_stat[2]) else $error("b rise");
    a_fall_b: assert property ($fell(port0_in[1]) |-> ##4 cap_stat[3]) else $error("b fall");
    a_cap_irq: assert property (irq_cap_a |->
        cap_stat[1:0] != 2'h0 && $past(cap_a_int_en)) else $error("capture irq");
    a_cap_irq_b: assert property (irq_cap_b |->
        cap_stat[3:2] != 2'h0 && $past(cap_b_int_en)) else $error("capture irq b");
    a_tick_phase: assert property (irq_tick128 |=> timer_lo[6:0] == 7'h00) else $error("tick phase");
    a_slow_phase: assert property (irq_tick1024 |=>
        {timer_hi[1:0], timer_lo} == 10'h000) else $error("slow tick phase");
endmodule
bind frtc_top frtc_chk u_chk (.clk_sys, .rst, .port0_in, .tick128_en, .tick1024_en,
    .cap_a_int_en, .cap_b_int_en, .timer_lo, .timer_hi, .cap_stat,
    .irq_tick128, .irq_tick1024, .irq_cap_a, .irq_cap_b);
`default_nettype wire

// file: sim/frtc_top_test.sv
// Purpose: Self-checking bench for frtc_top
// Assumes: Inputs change at falling edges
// Notes: Edges are placed just after a counter step so the slice is steady
`timescale 1ns/1ns
`default_nettype none
module frtc_top_test;
    logic       clk_sys = 1'b0, rst = 1'b1, tick128_en = 1'b0, tick1024_en = 1'b0, cap_first_only = 1'b0;
    logic       cap_a_int_en = 1'b1, cap_b_int_en = 1'b1;
    logic [7:0] port0_in = 8'h00;
    logic [2:0] cap_presc = 3'h0;
    logic [3:0] cap_stat_clr = 4'h0;
    logic [9:0] nt;
    logic [9:0] note_q[$];
    wire  [7:0] timer_lo, cap_a_rise, cap_a_fall, cap_b_rise, cap_b_fall;
    wire  [3:0] timer_hi, cap_stat;
    wire        irq_tick128, irq_tick1024, irq_cap_a, irq_cap_b;
    int         n_mismatch = 0, checked = 0, cyc = 0, last_t = 0, n_slow = 0;
    logic [7:0] exp_v, held;
    frtc_top DUT (.clk_sys, .rst, .port0_in, .tick128_en, .tick1024_en, .cap_a_int_en, .cap_b_int_en,
        .cap_presc, .cap_first_only, .cap_stat_clr, .timer_lo, .timer_hi, .cap_a_rise, .cap_a_fall,
        .cap_b_rise, .cap_b_fall, .cap_stat, .irq_tick128, .irq_tick1024, .irq_cap_a, .irq_cap_b);
    always #4 clk_sys = ~clk_sys;
    // ==========================================
    // Checking
    task cmp(input string nm, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task report_and_stop;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // 128 counter steps of 125 clocks each
    task cmp_gap(input logic [15:0] s);
        cmp("tick gap", 16'h3e80, s);
    endtask
    task cmp_cap(input logic [9:0] n);
        logic [7:0] s;
        s = n[9] ? (n[8] ? cap_b_rise : cap_b_fall) : (n[8] ? cap_a_rise : cap_a_fall);
        cmp("channel", {14'h0, n[9], !n[9]}, {14'h0, irq_cap_b, irq_cap_a});
        cmp("slice", {8'h0, n[7:0]}, {8'h0, s});
    endtask
    task cmp_count(input string nm, input logic [15:0] e, input logic [15:0] s);
        cmp(nm, e, s);
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            report_and_stop;
        end else begin
            #1;
            if (irq_tick1024 !== 1'b0) n_slow++;
            if (irq_tick128 === 1'b1) begin
                if (last_t != 0) cmp_gap(16'(cyc - last_t));
                last_t = cyc;
            end
            if (irq_cap_a === 1'b1 || irq_cap_b === 1'b1) begin
                if (note_q.size() == 0) begin
                    cmp_count("spurious capture irq", 16'h0, 16'h1);
                end else begin
                    nt = note_q.pop_front();
                    cmp_cap(nt);
                end
            end
        end
    end
    // ==========================================
    // Stimulus
    task edge_go(input logic ch, input logic pol, input logic ld);
        logic [11:0] t;
        @(timer_lo);
        @(negedge clk_sys);
        t = {timer_hi, timer_lo};
        exp_v = 8'(t >> (cap_presc > 3'h4 ? 3'h4 : cap_presc));
        if (ld && (ch ? cap_b_int_en : cap_a_int_en))
            note_q.push_back({ch, pol, exp_v});
        port0_in[ch] = pol;
        repeat (6) @(negedge clk_sys);
    endtask
    initial begin
        void'($urandom(78));
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            cap_presc = 3'($urandom_range(7, 0));
            cap_a_int_en = 1'($urandom);
            cap_b_int_en = 1'($urandom);
            edge_go(i[1], !i[0], 1'b1);
            cap_stat_clr = 4'hf;
            @(negedge clk_sys);
            cap_stat_clr = 4'h0;
        end
        cap_first_only = 1'b1;
        cap_a_int_en = 1'b1;
        // Finest slice so a wrongful reload would show a different value
        cap_presc = 3'h0;
        edge_go(1'b0, 1'b1, 1'b1);
        held = exp_v;
        edge_go(1'b0, 1'b0, 1'b1);
        edge_go(1'b0, 1'b1, 1'b0);
        cmp_count("held capture", {8'h0, held}, {8'h0, cap_a_rise});
        tick128_en = 1'b1;
        tick1024_en = 1'b1;
        repeat (2) @(posedge irq_tick128);
        repeat (4) @(negedge clk_sys);
        cmp_count("missing irq", 16'h0, 16'(note_q.size()));
        cmp_count("slow ticks", 16'h0, 16'(n_slow));
        report_and_stop;
    end
endmodule
`default_nettype wire
